//--- rtl/adccal_params.svh
// constants for the converter calibration control block
`ifndef ADCCAL_PARAMS_SVH
`define ADCCAL_PARAMS_SVH

// device register offsets on the register port
`define ADCCAL_REF_SOURCE_OFFS    8'h38
`define ADCCAL_STAMP_CTRL_OFFS    8'h3b
`define ADCCAL_SWING_CTRL_OFFS    8'h48
`define ADCCAL_INPUT_SEL_OFFS     8'h60
`define ADCCAL_RUN_CTRL_OFFS      8'h61
`define ADCCAL_CFG_OFFS           8'h62
`define ADCCAL_AVG_OFFS           8'h68
`define ADCCAL_STATE_OFFS         8'h6a
`define ADCCAL_PIN_CFG_OFFS       8'h6b
`define ADCCAL_SOFT_TRIG_OFFS     8'h6c

// reset values
`define ADCCAL_REF_SOURCE_RST     8'h00
`define ADCCAL_STAMP_CTRL_RST     8'h00
`define ADCCAL_SWING_CTRL_RST     8'h00
`define ADCCAL_INPUT_SEL_RST      8'h01
`define ADCCAL_RUN_CTRL_RST       8'h01
`define ADCCAL_CFG_RST            8'h01
`define ADCCAL_AVG_RST            8'h61
`define ADCCAL_PIN_CFG_RST        8'h00
`define ADCCAL_SOFT_TRIG_RST      8'h01

// field positions
`define ADCCAL_STAMP_RECV_BIT     0
`define ADCCAL_STAMP_DC_BIT       1
`define ADCCAL_DUAL_SWAP_BIT      4
`define ADCCAL_FG_BIT             0
`define ADCCAL_BG_BIT             1
`define ADCCAL_FG_OS_BIT          2
`define ADCCAL_BG_OS_BIT          3
`define ADCCAL_AVG_LSB            4
`define ADCCAL_AVG_LOW_FIXED      4'h1
`define ADCCAL_STAT_SEL_LSB       1
`define ADCCAL_TRIG_SRC_BIT       0
`define ADCCAL_SINGLE_IN_A        2'h1
`define ADCCAL_SINGLE_IN_B        2'h2

// foreground run length at averaging amount zero, doubled per averaging step, in clock cycles
`define ADCCAL_FG_BASE_CYCLES     16

// host register offsets on apb
`define ADCCAL_H_CMD_OFFS         12'h000
`define ADCCAL_H_STATUS_OFFS      12'h004
`define ADCCAL_H_PIN_OFFS         12'h008
`define ADCCAL_H_WRITE_BIT        16
`define ADCCAL_H_BUSY_BIT         0
`define ADCCAL_H_REFUSED_BIT      1
`define ADCCAL_H_PIN_RST          1'b1

`endif

//--- rtl/adccal_pkg.sv
// types shared by both ends of the calibration control link
package adccal_pkg;

  typedef enum logic [4:0] {
    ADCCAL_HOLD    = 5'b00001,
    ADCCAL_FG_RUN  = 5'b00010,
    ADCCAL_BG_RUN  = 5'b00100,
    ADCCAL_STOPPED = 5'b01000,
    ADCCAL_DONE    = 5'b10000
  } adccal_state_type;

  typedef enum logic [1:0] {
    ADCCAL_HIGH_SWING          = 2'h0,
    ADCCAL_LOW_SWING           = 2'h1,
    ADCCAL_SWING_RESERVED      = 2'h2,
    ADCCAL_LOW_SWING_HIGHZ_LOAD = 2'h3
  } adccal_swing_type;

  typedef enum logic [1:0] {
    ADCCAL_PIN_FOREGROUND_COMPLETE = 2'h0,
    ADCCAL_PIN_STOPPED = 2'h1,
    ADCCAL_PIN_ALARM   = 2'h2,
    ADCCAL_PIN_LOW     = 2'h3
  } adccal_pin_sel_type;

endpackage

//--- rtl/adccal_if.sv
// register port and pins between host controller and converter
`timescale 1ns/1ns
interface adccal_if;
  logic       req;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       hardware_trigger_pin;
  logic       status_output_pin;

  modport device (
    input  req, wr, addr, wdata, hardware_trigger_pin,
    output ack, rdata, status_output_pin
  );

  modport host (
    output req, wr, addr, wdata, hardware_trigger_pin,
    input  ack, rdata, status_output_pin
  );
endinterface

//--- rtl/adccal_device.sv
// converter end: register file, calibration sequencer and control outputs
//
// Chosen here: a req/ack register port to the registers; APB is on the host end.
`timescale 1ns/1ns
`include "adccal_params.svh"

module adccal_device
  import adccal_pkg::*;
#(
  parameter int FG_BASE_CYCLES = `ADCCAL_FG_BASE_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  adccal_if.device         link,
  input  wire logic        alarm_i,
  input  wire logic        lowpower_triggered_mode_i,
  output logic             reference_source_select_o,
  output logic             stamp_receiver_on_o,
  output logic             stamp_input_dc_mode_o,
  output adccal_swing_type swing_mode_o,
  output logic             channel_swap_o,
  output logic [1:0]       single_input_o,
  output logic             cal_reset_o,
  output logic             divider_reset_o,
  output logic             fg_cal_run_o,
  output logic             fg_offset_run_o,
  output logic             bg_cal_run_o,
  output logic             bg_offset_run_o,
  output logic [2:0]       offset_averaging_amount_o,
  output logic             core_wake_o
);

  localparam logic [15:0] FG_BASE = 16'(FG_BASE_CYCLES);

  logic             ref_reg;
  logic [1:0]       stamp_reg;
  logic [1:0]       swing_reg;
  logic             swap_reg;
  logic [1:0]       single_reg;
  logic             cal_en_reg;
  logic [3:0]       cfg_reg;
  logic [2:0]       avg_reg;
  logic [1:0]       pin_sel_reg;
  logic             trig_src_reg;
  logic             soft_trig_reg;
  logic [3:0]       cfg_shadow_reg;
  logic [2:0]       avg_shadow_reg;
  adccal_state_type state_reg;
  adccal_state_type state_next;
  logic [15:0]      count_reg;
  logic             foreground_complete_reg;
  logic             ack_reg;
  logic [7:0]       rdata_reg;
  logic             status_pin_reg;
  logic             trig;
  logic             write_en;
  logic             fg_on;
  logic             bg_on;
  logic             cal_stopped;
  logic [2:0]       stat_code;
  logic [7:0]       rd_value;

  assign write_en = link.req & link.wr;

  // register writes; reserved bits are not stored and read back as zero, except averaging bits 3:0, which read back as 0001
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ref_reg       <= 1'(`ADCCAL_REF_SOURCE_RST);
      stamp_reg     <= 2'(`ADCCAL_STAMP_CTRL_RST);
      swing_reg     <= 2'(`ADCCAL_SWING_CTRL_RST);
      swap_reg      <= 1'b0;
      single_reg    <= 2'(`ADCCAL_INPUT_SEL_RST);
      cal_en_reg    <= 1'(`ADCCAL_RUN_CTRL_RST);
      cfg_reg       <= 4'(`ADCCAL_CFG_RST);
      avg_reg       <= 3'(`ADCCAL_AVG_RST >> `ADCCAL_AVG_LSB);
      pin_sel_reg   <= 2'(`ADCCAL_PIN_CFG_RST >> `ADCCAL_STAT_SEL_LSB);
      trig_src_reg  <= 1'(`ADCCAL_PIN_CFG_RST);
      soft_trig_reg <= 1'(`ADCCAL_SOFT_TRIG_RST);
    end else if (write_en) begin
      if (link.addr == `ADCCAL_REF_SOURCE_OFFS) begin
        ref_reg <= link.wdata[0];
      end else if (link.addr == `ADCCAL_STAMP_CTRL_OFFS) begin
        stamp_reg <= link.wdata[1:0];
      end else if (link.addr == `ADCCAL_SWING_CTRL_OFFS) begin
        swing_reg <= link.wdata[1:0];
      end else if (link.addr == `ADCCAL_INPUT_SEL_OFFS) begin
        swap_reg   <= link.wdata[`ADCCAL_DUAL_SWAP_BIT];
        single_reg <= link.wdata[1:0];
      end else if (link.addr == `ADCCAL_RUN_CTRL_OFFS) begin
        cal_en_reg <= link.wdata[0];
      end else if (link.addr == `ADCCAL_CFG_OFFS) begin
        cfg_reg <= link.wdata[3:0];
      end else if (link.addr == `ADCCAL_AVG_OFFS) begin
        avg_reg <= link.wdata[`ADCCAL_AVG_LSB +: 3];
      end else if (link.addr == `ADCCAL_PIN_CFG_OFFS) begin
        pin_sel_reg  <= link.wdata[`ADCCAL_STAT_SEL_LSB +: 2];
        trig_src_reg <= link.wdata[`ADCCAL_TRIG_SRC_BIT];
      end else if (link.addr == `ADCCAL_SOFT_TRIG_OFFS) begin
        soft_trig_reg <= link.wdata[0];
      end
    end
  end

  // settings reach the sequencer only while it is held, so a running
  // calibration never sees a half-changed configuration
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cfg_shadow_reg <= 4'(`ADCCAL_CFG_RST);
      avg_shadow_reg <= 3'(`ADCCAL_AVG_RST >> `ADCCAL_AVG_LSB);
    end else if (!cal_en_reg) begin
      cfg_shadow_reg <= cfg_reg;
      avg_shadow_reg <= avg_reg;
    end
  end

  assign trig  = trig_src_reg ? link.hardware_trigger_pin : soft_trig_reg;
  assign fg_on = cfg_shadow_reg[`ADCCAL_FG_BIT];
  assign bg_on = cfg_shadow_reg[`ADCCAL_BG_BIT];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ADCCAL_HOLD: begin
        if (cal_en_reg) begin
          if (fg_on) begin
            state_next = ADCCAL_FG_RUN;
          end else if (bg_on) begin
            state_next = ADCCAL_BG_RUN;
          end else begin
            state_next = ADCCAL_DONE;
          end
        end
      end
      ADCCAL_FG_RUN: begin
        if (count_reg == 16'h0001) begin
          state_next = bg_on ? ADCCAL_BG_RUN : ADCCAL_DONE;
        end
      end
      ADCCAL_BG_RUN: begin
        if (!trig) begin
          state_next = ADCCAL_STOPPED;
        end
      end
      ADCCAL_STOPPED: begin
        if (trig) begin
          state_next = ADCCAL_BG_RUN;
        end
      end
      ADCCAL_DONE: begin
        state_next = ADCCAL_DONE;
      end
      default: begin
        state_next = ADCCAL_HOLD;
      end
    endcase
    if (!cal_en_reg) begin
      state_next = ADCCAL_HOLD;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_reg <= ADCCAL_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // foreground length grows with the averaging amount
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      count_reg <= 16'h0000;
    end else if (state_reg == ADCCAL_HOLD) begin
      count_reg <= FG_BASE << avg_shadow_reg;
    end else if (state_reg == ADCCAL_FG_RUN) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  // cleared while held, so each start resets the calibration results
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      foreground_complete_reg <= 1'b0;
    end else if (state_next == ADCCAL_HOLD) begin
      foreground_complete_reg <= 1'b0;
    end else if (state_reg != state_next && state_next != ADCCAL_FG_RUN) begin
      foreground_complete_reg <= 1'b1;
    end
  end

  assign cal_stopped = (state_reg == ADCCAL_STOPPED) || (state_reg == ADCCAL_DONE);

  always_comb begin
    stat_code = 3'h0;
    case (state_reg)
      ADCCAL_FG_RUN:  stat_code = 3'h1;
      ADCCAL_BG_RUN:  stat_code = 3'h2;
      ADCCAL_STOPPED: stat_code = 3'h3;
      ADCCAL_DONE:    stat_code = 3'h4;
      default:        stat_code = 3'h0;
    endcase
  end

  always_comb begin
    rd_value = 8'h00;
    if (link.addr == `ADCCAL_REF_SOURCE_OFFS) begin
      rd_value = {7'h00, ref_reg};
    end else if (link.addr == `ADCCAL_STAMP_CTRL_OFFS) begin
      rd_value = {6'h00, stamp_reg};
    end else if (link.addr == `ADCCAL_SWING_CTRL_OFFS) begin
      rd_value = {6'h00, swing_reg};
    end else if (link.addr == `ADCCAL_INPUT_SEL_OFFS) begin
      rd_value = {3'h0, swap_reg, 2'h0, single_reg};
    end else if (link.addr == `ADCCAL_RUN_CTRL_OFFS) begin
      rd_value = {7'h00, cal_en_reg};
    end else if (link.addr == `ADCCAL_CFG_OFFS) begin
      rd_value = {4'h0, cfg_reg};
    end else if (link.addr == `ADCCAL_AVG_OFFS) begin
      rd_value = {1'b0, avg_reg, `ADCCAL_AVG_LOW_FIXED};
    end else if (link.addr == `ADCCAL_STATE_OFFS) begin
      rd_value = {3'h0, stat_code, cal_stopped, foreground_complete_reg};
    end else if (link.addr == `ADCCAL_PIN_CFG_OFFS) begin
      rd_value = {5'h00, pin_sel_reg, trig_src_reg};
    end else if (link.addr == `ADCCAL_SOFT_TRIG_OFFS) begin
      rd_value = {7'h00, soft_trig_reg};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= link.req;
      if (link.req && !link.wr) begin
        rdata_reg <= rd_value;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      status_pin_reg <= 1'b0;
    end else begin
      case (adccal_pin_sel_type'(pin_sel_reg))
        ADCCAL_PIN_FOREGROUND_COMPLETE: status_pin_reg <= foreground_complete_reg;
        ADCCAL_PIN_STOPPED: status_pin_reg <= cal_stopped;
        ADCCAL_PIN_ALARM:   status_pin_reg <= alarm_i;
        default:            status_pin_reg <= 1'b0;
      endcase
    end
  end

  assign link.ack               = ack_reg;
  assign link.rdata             = rdata_reg;
  assign link.status_output_pin = status_pin_reg;

  assign reference_source_select_o = ref_reg;
  assign stamp_receiver_on_o       = stamp_reg[`ADCCAL_STAMP_RECV_BIT];
  assign stamp_input_dc_mode_o     = stamp_reg[`ADCCAL_STAMP_DC_BIT];
  assign swing_mode_o              = adccal_swing_type'(swing_reg);
  assign channel_swap_o            = swap_reg;
  assign single_input_o            = single_reg;
  assign cal_reset_o               = ~cal_en_reg;
  assign divider_reset_o           = ~cal_en_reg;
  assign fg_cal_run_o              = (state_reg == ADCCAL_FG_RUN);
  assign fg_offset_run_o           = fg_cal_run_o & cfg_shadow_reg[`ADCCAL_FG_OS_BIT];
  assign bg_cal_run_o              = (state_reg == ADCCAL_BG_RUN);
  assign bg_offset_run_o           = bg_cal_run_o & cfg_shadow_reg[`ADCCAL_BG_OS_BIT];
  assign offset_averaging_amount_o = avg_shadow_reg;
  assign core_wake_o               = lowpower_triggered_mode_i & ~trig;

endmodule // adccal_device

//--- rtl/adccal_host.sv
// host end: apb slave that turns software commands into register port cycles
`timescale 1ns/1ns
`include "adccal_params.svh"

module adccal_host
  import adccal_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  adccal_if.host           link
);

  logic       busy_reg;
  logic       req_reg;
  logic       wr_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic       refused_reg;
  logic       cal_en_reg;
  logic       trig_pin_reg;
  logic       apb_wr;
  logic       cmd_wr;
  logic       cmd_is_write;
  logic [7:0] cmd_addr;
  logic       cmd_refuse;
  logic       mapped;

  assign apb_wr       = psel & penable & pwrite;
  assign cmd_wr       = apb_wr && (paddr == `ADCCAL_H_CMD_OFFS);
  assign cmd_is_write = pwdata[`ADCCAL_H_WRITE_BIT];
  assign cmd_addr     = pwdata[7:0];
  // known enable high: changing calibration settings now is refused
  assign cmd_refuse   = cmd_is_write && cal_en_reg &&
                        (cmd_addr == `ADCCAL_CFG_OFFS || cmd_addr == `ADCCAL_AVG_OFFS);

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      busy_reg  <= 1'b0;
      req_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      addr_reg  <= 8'h00;
      wdata_reg <= 8'h00;
    end else begin
      req_reg <= 1'b0;
      if (cmd_wr && !busy_reg && !cmd_refuse) begin
        busy_reg  <= 1'b1;
        req_reg   <= 1'b1;
        wr_reg    <= cmd_is_write;
        addr_reg  <= cmd_addr;
        wdata_reg <= pwdata[15:8];
      end else if (link.ack) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rdata_reg <= 8'h00;
    end else if (link.ack && !wr_reg) begin
      rdata_reg <= link.rdata;
    end
  end

  // tracks the enable the device holds, starting at its reset value
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cal_en_reg <= 1'(`ADCCAL_RUN_CTRL_RST);
    end else if (link.ack && wr_reg && addr_reg == `ADCCAL_RUN_CTRL_OFFS) begin
      cal_en_reg <= wdata_reg[0];
    end
  end

  // new refusal wins over a clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      refused_reg <= 1'b0;
    end else if (cmd_wr && (busy_reg || cmd_refuse)) begin
      refused_reg <= 1'b1;
    end else if (apb_wr && paddr == `ADCCAL_H_STATUS_OFFS && pwdata[`ADCCAL_H_REFUSED_BIT]) begin
      refused_reg <= 1'b0;
    end
  end

  // pin rests high so an unused trigger never stops calibration
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      trig_pin_reg <= `ADCCAL_H_PIN_RST;
    end else if (apb_wr && paddr == `ADCCAL_H_PIN_OFFS) begin
      trig_pin_reg <= pwdata[0];
    end
  end

  assign mapped = (paddr == `ADCCAL_H_CMD_OFFS) || (paddr == `ADCCAL_H_STATUS_OFFS) ||
                  (paddr == `ADCCAL_H_PIN_OFFS);

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == `ADCCAL_H_CMD_OFFS) begin
      prdata = {15'h0000, wr_reg, wdata_reg, addr_reg};
    end else if (paddr == `ADCCAL_H_STATUS_OFFS) begin
      prdata = {16'h0000, rdata_reg, 6'h00, refused_reg, busy_reg};
    end else if (paddr == `ADCCAL_H_PIN_OFFS) begin
      prdata = {30'h0000_0000, link.status_output_pin, trig_pin_reg};
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  assign link.req                  = req_reg;
  assign link.wr                   = wr_reg;
  assign link.addr                 = addr_reg;
  assign link.wdata                = wdata_reg;
  assign link.hardware_trigger_pin = trig_pin_reg;

endmodule // adccal_host

//--- bench/adccal_assertions.sv
// concurrent checks on the register link between host and converter ends
`timescale 1ns/1ns
module adccal_assertions (
  input wire logic       clock_i,
  input wire logic       resetn_i,
  input wire logic       req,
  input wire logic       wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       hardware_trigger_pin,
  input wire logic       status_output_pin
);
  logic [7:0] addr_reg;
  logic       rd_reg;
  logic       en_reg;
  logic [1:0] off_reg;
  logic [1:0] sel_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      addr_reg <= 8'h00;
      rd_reg   <= 1'b0;
    end else if (req) begin
      addr_reg <= addr;
      rd_reg   <= !wr;
    end
  end

  // mirrors of enable and pin select, updated at the same edge as the device
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      en_reg  <= 1'b1;
      sel_reg <= 2'h0;
    end else if (req && wr && addr == 8'h61) begin
      en_reg <= wdata[0];
    end else if (req && wr && addr == 8'h6b) begin
      sel_reg <= wdata[2:1];
    end
  end

  // saturating count of edges seen with enable low
  always_ff @(posedge clock_i) begin
    if (!resetn_i || en_reg) begin
      off_reg <= 2'h0;
    end else if (off_reg != 2'h3) begin
      off_reg <= off_reg + 2'h1;
    end
  end

  property p_ack_next;
    req |=> ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after req");
  property p_ack_cause;
    ack |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
  property p_req_pulse;
    req |=> !req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("req longer than one cycle");
  property p_rdata_hold;
    $changed(rdata) |-> $past(req) && !$past(wr);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata changed without read");
  property p_run_rsvd;
    ack && rd_reg && addr_reg == 8'h61 |-> rdata[7:1] == 7'h00;
  endproperty
  a_run_rsvd: assert property (p_run_rsvd) else $error("enable reg spare bits set");
  property p_avg_fixed;
    ack && rd_reg && addr_reg == 8'h68 |-> rdata[3:0] == 4'h1 && !rdata[7];
  endproperty
  a_avg_fixed: assert property (p_avg_fixed) else $error("averaging reg fixed bits wrong");
  property p_stop_code;
    ack && rd_reg && addr_reg == 8'h6a |-> rdata[1] == (rdata[4:2] == 3'h3 || rdata[4:2] == 3'h4);
  endproperty
  a_stop_code: assert property (p_stop_code) else $error("stopped bit disagrees with code");
  property p_done_code;
    ack && rd_reg && addr_reg == 8'h6a && rdata[4:2] inside {3'h2, 3'h3, 3'h4} |-> rdata[0];
  endproperty
  a_done_code: assert property (p_done_code) else $error("foreground done missing");
  property p_hold;
    ack && rd_reg && addr_reg == 8'h6a && off_reg == 2'h3 |-> rdata[4:0] == 5'h00;
  endproperty
  a_hold: assert property (p_hold) else $error("calibration not held while disabled");
  property p_pin_low;
    sel_reg == 2'h3 && $past(sel_reg) == 2'h3 |-> !status_output_pin;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("status pin high in low mode");

  c_status_read: cover property (ack && rd_reg && addr_reg == 8'h6a);
  c_held: cover property (off_reg == 2'h3);
  c_pin_low: cover property (sel_reg == 2'h3);
endmodule // adccal_assertions

//--- bench/adc_calibration_control_tb_top.sv
// self-checking bench for the host and converter ends joined by their link
`timescale 1ns/1ns
module adc_calibration_control_tb_top;
  import adccal_pkg::*;
  logic             clock_i = 1'b0;
  logic             resetn_i = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata, rv;
  logic             pready, pslverr, serr;
  logic             alarm_i = 1'b0;
  logic             lowpower_triggered_mode_i = 1'b0;
  logic             reference_source_select_o, stamp_receiver_on_o, stamp_input_dc_mode_o, channel_swap_o;
  logic             cal_reset_o, divider_reset_o, fg_cal_run_o, fg_offset_run_o, bg_cal_run_o, bg_offset_run_o;
  logic             core_wake_o;
  adccal_swing_type swing_mode_o;
  logic [1:0]       single_input_o;
  logic [2:0]       offset_averaging_amount_o;
  int               error_cnt = 0;
  int               checks_done = 0;
  int               cyc = 0;

  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 1;

  adccal_if adccal_if_i ();
  adccal_host adccal_host_i (.clock_i, .resetn_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .link(adccal_if_i.host));
  // short foreground runs keep the averaging test brief
  adccal_device #(.FG_BASE_CYCLES(2)) adccal_device_i (.clock_i, .resetn_i, .link(adccal_if_i.device), .alarm_i,
    .lowpower_triggered_mode_i, .reference_source_select_o, .stamp_receiver_on_o, .stamp_input_dc_mode_o,
    .swing_mode_o, .channel_swap_o, .single_input_o, .cal_reset_o, .divider_reset_o, .fg_cal_run_o,
    .fg_offset_run_o, .bg_cal_run_o, .bg_offset_run_o, .offset_averaging_amount_o, .core_wake_o);
  adccal_assertions adccal_assertions_i (.clock_i, .resetn_i, .req(adccal_if_i.req), .wr(adccal_if_i.wr),
    .addr(adccal_if_i.addr), .wdata(adccal_if_i.wdata), .ack(adccal_if_i.ack), .rdata(adccal_if_i.rdata),
    .hardware_trigger_pin(adccal_if_i.hardware_trigger_pin), .status_output_pin(adccal_if_i.status_output_pin));

  task automatic results;
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      results;
    end
  endtask

  // device register access through the command word, then poll busy
  task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, 12'h000, {15'h0, w, d, a});
    for (n = 0; n < 30; n++) begin
      apb(1'b0, 12'h004, 32'h0);
      if (rv[0] === 1'b0) break;
    end
    if (n == 30) begin
      error_cnt++;
      results;
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    dev(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), e, rv[15:8]);
  endtask

  task automatic t_reset;
    logic [7:0] a[9] = '{8'h38, 8'h3b, 8'h48, 8'h60, 8'h61, 8'h62, 8'h68, 8'h6b, 8'h6c};
    logic [7:0] e[9] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h61, 8'h00, 8'h01};
    for (int i = 0; i < 9; i++) rdchk(a[i], e[i]);
    apb(1'b0, 12'h008, 32'h0);
    chk("trigger pin reset", 32'h1, rv[0]);
  endtask

  task automatic t_fields;
    dev(1'b1, 8'h38, 8'h01);
    chk("reference_source_select_o", 32'h1, reference_source_select_o);
    dev(1'b1, 8'h38, 8'h00);
    chk("reference_source_select_o", 32'h0, reference_source_select_o);
    dev(1'b1, 8'h3b, 8'hff);
    chk("stamp outputs", 32'h3, {stamp_input_dc_mode_o, stamp_receiver_on_o});
    rdchk(8'h3b, 8'h03);
    dev(1'b1, 8'h3b, 8'h02);
    chk("stamp outputs", 32'h2, {stamp_input_dc_mode_o, stamp_receiver_on_o});
    for (int i = 0; i < 4; i++) begin
      dev(1'b1, 8'h48, 8'(i));
      chk("swing_mode_o", i, swing_mode_o);
    end
    dev(1'b1, 8'h60, 8'h12);
    chk("input mux", 32'h6, {channel_swap_o, single_input_o});
    dev(1'b1, 8'h60, 8'h01);
    chk("input mux", 32'h1, {channel_swap_o, single_input_o});
  endtask

  // background only, stopped and resumed by the soft trigger
  task automatic t_cal;
    dev(1'b1, 8'h61, 8'h00);
    chk("reset outputs", 32'h3, {cal_reset_o, divider_reset_o});
    rdchk(8'h6a, 8'h00);
    dev(1'b1, 8'h62, 8'h0e);
    dev(1'b1, 8'h68, 8'h21);
    chk("offset_averaging_amount_o", 32'h2, offset_averaging_amount_o);
    dev(1'b1, 8'h61, 8'h01);
    chk("reset outputs", 32'h0, {cal_reset_o, divider_reset_o});
    chk("run outputs", 32'h3, {fg_cal_run_o, fg_offset_run_o, bg_cal_run_o, bg_offset_run_o});
    rdchk(8'h6a, 8'h09);
    dev(1'b1, 8'h6b, 8'h02);
    dev(1'b1, 8'h6c, 8'h00);
    rdchk(8'h6a, 8'h0f);
    chk("status_output_pin", 32'h1, adccal_if_i.status_output_pin);
    dev(1'b1, 8'h6c, 8'h01);
    rdchk(8'h6a, 8'h09);
    chk("status_output_pin", 32'h0, adccal_if_i.status_output_pin);
  endtask

  // hardware trigger selected: soft bit low must be ignored
  task automatic t_trig;
    lowpower_triggered_mode_i <= 1'b1;
    dev(1'b1, 8'h6b, 8'h03);
    dev(1'b1, 8'h6c, 8'h00);
    rdchk(8'h6a, 8'h09);
    chk("core_wake_o", 32'h0, core_wake_o);
    apb(1'b1, 12'h008, 32'h0);
    rdchk(8'h6a, 8'h0f);
    chk("core_wake_o", 32'h1, core_wake_o);
    apb(1'b1, 12'h008, 32'h1);
    dev(1'b1, 8'h6c, 8'h01);
    dev(1'b1, 8'h6b, 8'h00);
    lowpower_triggered_mode_i <= 1'b0;
  endtask

  // foreground with offset at largest averaging, no background
  task automatic t_fg;
    int n;
    int c0;
    dev(1'b1, 8'h61, 8'h00);
    dev(1'b1, 8'h62, 8'h05);
    dev(1'b1, 8'h68, 8'h71);
    dev(1'b1, 8'h61, 8'h01);
    c0 = cyc;
    chk("run outputs", 32'hc, {fg_cal_run_o, fg_offset_run_o, bg_cal_run_o, bg_offset_run_o});
    rdchk(8'h6a, 8'h04);
    chk("status_output_pin", 32'h0, adccal_if_i.status_output_pin);
    for (n = 0; n < 60; n++) begin
      dev(1'b0, 8'h6a, 8'h00);
      if (rv[15:8] === 8'h13) break;
    end
    chk("done status", 32'h13, rv[15:8]);
    if (n == 60) results;
    chk("foreground length", 32'h1, (cyc - c0) >= 256);
    chk("status_output_pin", 32'h1, adccal_if_i.status_output_pin);
  endtask

  task automatic t_refuse;
    dev(1'b1, 8'h62, 8'h02);
    chk("refused flag", 32'h1, rv[1]);
    rdchk(8'h62, 8'h05);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b0, 12'h004, 32'h0);
    chk("refused flag", 32'h0, rv[1]);
  endtask

  task automatic t_pins;
    alarm_i <= 1'b1;
    dev(1'b1, 8'h6b, 8'h04);
    chk("status_output_pin", 32'h1, adccal_if_i.status_output_pin);
    alarm_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("status_output_pin", 32'h0, adccal_if_i.status_output_pin);
    alarm_i <= 1'b1;
    dev(1'b1, 8'h6b, 8'h06);
    apb(1'b0, 12'h008, 32'h0);
    chk("pin reg", 32'h1, rv[1:0]);
    apb(1'b0, 12'h00c, 32'h0);
    chk("pslverr", 32'h1, serr);
    chk("unmapped prdata", 32'h0, rv);
    rdchk(8'h00, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset;
    t_fields;
    t_cal;
    t_trig;
    t_fg;
    t_refuse;
    t_pins;
    results;
  end

  initial begin
    repeat (100000) @(posedge clock_i);
    error_cnt++;
    results;
  end
endmodule // adc_calibration_control_tb_top
